/* inc/estop_map.svh */
// register offsets, field positions, reset values and timing counts of the stop sequencer
`ifndef ESTOP_MAP_SVH
`define ESTOP_MAP_SVH

`define ESTOP_NUM_AXES 4

`define ESTOP_OFF_CTRL 12'h000
`define ESTOP_OFF_STATUS 12'h004
`define ESTOP_OFF_ERROR 12'h008
`define ESTOP_OFF_BRAKE 12'h00C
`define ESTOP_OFF_CUTOUT 12'h010
`define ESTOP_OFF_AXIS 12'h014

`define ESTOP_CTRL_REQ 0
`define ESTOP_CTRL_ACK 1
`define ESTOP_CTRL_RES 2
`define ESTOP_CTRL_EN_LSB 8

`define ESTOP_ST_ACTIVE 0
`define ESTOP_ST_READY 1
`define ESTOP_ST_HALT 2
`define ESTOP_ST_REST 3
`define ESTOP_ST_CUT 4

`define ESTOP_AX_DRV_LSB 0
`define ESTOP_AX_FUP_LSB 8
`define ESTOP_AX_LOOP_LSB 16
`define ESTOP_AX_BRK_LSB 24

`define ESTOP_ERR_NONE 16'h0000
`define ESTOP_ERR_CODE 16'h0BB8

`define ESTOP_CTRL_RESET 32'h0000_0000
`define ESTOP_BRAKE_RESET 16'h0064
`define ESTOP_CUTOUT_RESET 16'h00C8

`define ESTOP_CLK_PERIOD_NS 8
`define ESTOP_TICK_NS 1000
`define ESTOP_TICK_CYCLES ((`ESTOP_TICK_NS + `ESTOP_CLK_PERIOD_NS - 1) / `ESTOP_CLK_PERIOD_NS)

`endif

/* inc/estop_pkg.sv */
// types shared by the stop sequencer files
`include "estop_map.svh"
package estop_pkg;
    typedef enum logic {ST_RUN, ST_STOP} estop_state_t;
    typedef logic [15:0] delay_t;
    typedef logic [`ESTOP_NUM_AXES-1:0] axis_vec_t;
    typedef logic [11:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
endpackage

/* logic/estop_tick_divider.sv */
// divider that makes the one-cycle cyclic-operation tick
`timescale 1ns/1ns
`include "estop_map.svh"
module estop_tick_divider (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    output logic tickEn // one-cycle pulse per cycle period
);
    localparam int unsigned TICK_CYCLES = `ESTOP_TICK_CYCLES;
    logic [7:0] divCnt_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt_reg <= 8'h00;
            tickEn <= 1'b0;
        end else if (divCnt_reg == 8'(TICK_CYCLES - 1)) begin
            divCnt_reg <= 8'h00;
            tickEn <= 1'b1;
        end else begin
            divCnt_reg <= divCnt_reg + 8'h01;
            tickEn <= 1'b0;
        end
    end
endmodule

/* logic/estop_delay_timer.sv */
// tick-based delay that raises done once the loaded count has run out
`timescale 1ns/1ns
module estop_delay_timer (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic start, // pulse: load and run
    input wire logic abort, // pulse: stop and drop done
    input wire logic tickEn, // cyclic tick
    input wire estop_pkg::delay_t loadValue, // delay in ticks
    output logic done // level: delay has elapsed
);
    import estop_pkg::*;
    delay_t count_reg;
    logic running_reg;

    always_ff @(posedge sys_clk) begin
        if (rst || abort) begin
            count_reg <= 16'h0000;
            running_reg <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            count_reg <= loadValue;
            running_reg <= 1'b1;
            done <= 1'b0;
        end else if (running_reg && count_reg == 16'h0000) begin
            // a zero delay finishes one cycle after start
            running_reg <= 1'b0;
            done <= 1'b1;
        end else if (running_reg && tickEn) begin
            count_reg <= count_reg - 16'h0001;
        end
    end
endmodule

/* logic/emergency_stop_sequencer.sv */
// emergency-stop sequencer with its APB register file
`timescale 1ns/1ns
`include "estop_map.svh"
// Notes on behaviour
// - a stop request halts the running part program.
// - a stop request brakes every axis to rest within the braking time.
// - a stop request clears the controller ready flag.
// - a stop request sets the stop active flag.
// - a stop request reports error number 3000.
// - drive enable is withdrawn once the cutout delay has elapsed.
// - a stop request puts every axis into follow-up mode.
// - acknowledge together with reset, once the request bit is clear, clears the stop state and active flag.
// - acknowledge alone leaves the stop state unchanged.
// - reset alone leaves the stop state unchanged.
// - after clearing, drive enable passes through again.
// - after clearing, axes leave follow-up mode.
// - after clearing, the position loop active flag is set for each axis whose enable request bit is set.
// - after clearing, the controller ready flag is set again.
// - after clearing, the stop active flag drops.
// - after clearing, error 3000 is withdrawn.
module emergency_stop_sequencer (
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire estop_pkg::apb_addr_t paddr, // APB byte address
    input wire estop_pkg::apb_data_t pwdata, // APB write data
    output estop_pkg::apb_data_t prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic programHalt, // level: part program held
    output estop_pkg::axis_vec_t driveEnable, // controller enable to drives
    output estop_pkg::axis_vec_t followUp, // setpoint tracks actual position
    output estop_pkg::axis_vec_t axisBrake, // braking ramp active per axis
    output estop_pkg::axis_vec_t positionLoopActive // position loop closed per axis
);
    import estop_pkg::*;

    function automatic logic addrIs(input apb_addr_t a, input apb_addr_t off);
        addrIs = (a == off);
    endfunction

    function automatic logic addrMapped(input apb_addr_t a);
        addrMapped = addrIs(a, `ESTOP_OFF_CTRL) || addrIs(a, `ESTOP_OFF_STATUS) ||
                     addrIs(a, `ESTOP_OFF_ERROR) || addrIs(a, `ESTOP_OFF_BRAKE) ||
                     addrIs(a, `ESTOP_OFF_CUTOUT) || addrIs(a, `ESTOP_OFF_AXIS);
    endfunction

    apb_data_t ctrl_reg;
    delay_t brakeTime_reg;
    delay_t cutoutTime_reg;
    estop_state_t state_reg;
    logic estopActive_reg;
    logic controllerReady_reg;
    delay_t errorCode_reg;
    logic tickEn;
    logic brakeDone;
    logic cutoutDone;

    logic setupPhase;
    logic writeAccess;
    logic estopRequest;
    logic estopAcknowledge;
    logic generalResetRequest;
    axis_vec_t enableRequest;
    logic enterStop;
    logic clearStop;

    assign setupPhase = psel && !penable;
    assign writeAccess = psel && penable && pwrite;
    assign estopRequest = ctrl_reg[`ESTOP_CTRL_REQ];
    assign estopAcknowledge = ctrl_reg[`ESTOP_CTRL_ACK];
    assign generalResetRequest = ctrl_reg[`ESTOP_CTRL_RES];
    assign enableRequest = ctrl_reg[`ESTOP_CTRL_EN_LSB +: `ESTOP_NUM_AXES];

    // the host program sets the request bit from the pushbutton
    assign enterStop = (state_reg == ST_RUN) && estopRequest;
    // both bits together, and only once the request is gone
    assign clearStop = (state_reg == ST_STOP) && estopAcknowledge &&
                       generalResetRequest && !estopRequest;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrMapped(paddr);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= `ESTOP_CTRL_RESET;
        end else if (writeAccess && addrIs(paddr, `ESTOP_OFF_CTRL)) begin
            ctrl_reg <= pwdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            brakeTime_reg <= `ESTOP_BRAKE_RESET;
            cutoutTime_reg <= `ESTOP_CUTOUT_RESET;
        end else if (writeAccess && addrIs(paddr, `ESTOP_OFF_BRAKE)) begin
            brakeTime_reg <= pwdata[15:0];
        end else if (writeAccess && addrIs(paddr, `ESTOP_OFF_CUTOUT)) begin
            cutoutTime_reg <= pwdata[15:0];
        end
    end

    // read data is captured in the setup cycle so it stands from a flop in the access cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `ESTOP_OFF_CTRL: begin
                    prdata <= ctrl_reg;
                end
                `ESTOP_OFF_STATUS: begin
                    prdata[`ESTOP_ST_ACTIVE] <= estopActive_reg;
                    prdata[`ESTOP_ST_READY] <= controllerReady_reg;
                    prdata[`ESTOP_ST_HALT] <= programHalt;
                    prdata[`ESTOP_ST_REST] <= brakeDone;
                    prdata[`ESTOP_ST_CUT] <= cutoutDone;
                end
                `ESTOP_OFF_ERROR: begin
                    prdata[15:0] <= errorCode_reg;
                end
                `ESTOP_OFF_BRAKE: begin
                    prdata[15:0] <= brakeTime_reg;
                end
                `ESTOP_OFF_CUTOUT: begin
                    prdata[15:0] <= cutoutTime_reg;
                end
                `ESTOP_OFF_AXIS: begin
                    prdata[`ESTOP_AX_DRV_LSB +: `ESTOP_NUM_AXES] <= driveEnable;
                    prdata[`ESTOP_AX_FUP_LSB +: `ESTOP_NUM_AXES] <= followUp;
                    prdata[`ESTOP_AX_LOOP_LSB +: `ESTOP_NUM_AXES] <= positionLoopActive;
                    prdata[`ESTOP_AX_BRK_LSB +: `ESTOP_NUM_AXES] <= axisBrake;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    estop_tick_divider u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tickEn(tickEn)
    );

    // braking window: axes must be at rest when it runs out
    estop_delay_timer u_brake (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(enterStop),
        .abort(clearStop),
        .tickEn(tickEn),
        .loadValue(brakeTime_reg),
        .done(brakeDone)
    );

    // enable cutout delay runs in parallel with braking
    estop_delay_timer u_cutout (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(enterStop),
        .abort(clearStop),
        .tickEn(tickEn),
        .loadValue(cutoutTime_reg),
        .done(cutoutDone)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (enterStop) begin
                        state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (clearStop) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // interface flags and error number follow the state change in the same edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            estopActive_reg <= 1'b0;
            controllerReady_reg <= 1'b1;
            errorCode_reg <= `ESTOP_ERR_NONE;
            programHalt <= 1'b0;
        end else if (enterStop) begin
            estopActive_reg <= 1'b1;
            controllerReady_reg <= 1'b0;
            errorCode_reg <= `ESTOP_ERR_CODE;
            programHalt <= 1'b1;
        end else if (clearStop) begin
            estopActive_reg <= 1'b0;
            controllerReady_reg <= 1'b1;
            errorCode_reg <= `ESTOP_ERR_NONE;
            programHalt <= 1'b0;
        end
    end

    genvar ax;
    generate
        for (ax = 0; ax < `ESTOP_NUM_AXES; ax++) begin : g_axis
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    driveEnable[ax] <= 1'b0;
                    followUp[ax] <= 1'b0;
                    axisBrake[ax] <= 1'b0;
                    positionLoopActive[ax] <= 1'b0;
                end else if (enterStop) begin
                    followUp[ax] <= 1'b1;
                    axisBrake[ax] <= 1'b1;
                    positionLoopActive[ax] <= 1'b0;
                end else if (clearStop) begin
                    driveEnable[ax] <= enableRequest[ax];
                    followUp[ax] <= 1'b0;
                    axisBrake[ax] <= 1'b0;
                    positionLoopActive[ax] <= enableRequest[ax];
                end else if (state_reg == ST_STOP) begin
                    // enable stays on through the delay so the drives can brake under control
                    driveEnable[ax] <= enableRequest[ax] && !cutoutDone;
                    axisBrake[ax] <= !brakeDone;
                end else begin
                    driveEnable[ax] <= enableRequest[ax];
                    positionLoopActive[ax] <= enableRequest[ax];
                end
            end
        end
    endgenerate

    // checks

    sequence s_clear_cond;
        (state_reg == ST_STOP) && estopAcknowledge && generalResetRequest && !estopRequest;
    endsequence

    sequence s_entry;
        (state_reg == ST_RUN) && estopRequest;
    endsequence

    a_entry_flags: assert property (@(posedge sys_clk) disable iff (rst)
        s_entry |=> estopActive_reg && !controllerReady_reg && (state_reg == ST_STOP))
        else $error("stop entry did not set active and clear ready");

    a_entry_error: assert property (@(posedge sys_clk) disable iff (rst)
        s_entry |=> (errorCode_reg == 16'h0BB8) && programHalt)
        else $error("stop entry did not report error 3000 or halt the program");

    a_halt_held: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) |-> programHalt && (errorCode_reg == 16'h0BB8))
        else $error("program not halted while stop state holds");

    a_follow_up: assert property (@(posedge sys_clk) disable iff (rst)
        s_entry |=> (followUp == '1) until (state_reg == ST_RUN))
        else $error("axes left follow-up during stop state");

    a_brake_ramp: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) && $past(state_reg == ST_STOP) && !$past(brakeDone)
        |-> (axisBrake == '1))
        else $error("axis brake released before braking window ran out");

    a_cutout_off: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) && cutoutDone && !clearStop |=> (driveEnable == '0))
        else $error("drive enable still on after cutout delay");

    a_ack_alone: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) && estopAcknowledge && !generalResetRequest
        |=> (state_reg == ST_STOP) && estopActive_reg)
        else $error("acknowledge alone cleared the stop state");

    a_reset_alone: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) && generalResetRequest && !estopAcknowledge
        |=> (state_reg == ST_STOP) && estopActive_reg)
        else $error("reset alone cleared the stop state");

    a_req_blocks: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_STOP) && estopRequest |=> (state_reg == ST_STOP))
        else $error("stop state cleared while request still set");

    a_clear_flags: assert property (@(posedge sys_clk) disable iff (rst)
        s_clear_cond |=> !estopActive_reg && controllerReady_reg && !programHalt)
        else $error("clearing did not restore ready and drop active");

    a_clear_error: assert property (@(posedge sys_clk) disable iff (rst)
        s_clear_cond |=> (errorCode_reg == 16'h0000) && (state_reg == ST_RUN))
        else $error("error 3000 not withdrawn on clearing");

    a_clear_axes: assert property (@(posedge sys_clk) disable iff (rst)
        s_clear_cond |=> (followUp == '0) && (driveEnable == $past(enableRequest)))
        else $error("axes not released from follow-up or enable not restored");

    a_loop_active: assert property (@(posedge sys_clk) disable iff (rst)
        s_clear_cond |=> (positionLoopActive == $past(enableRequest)))
        else $error("position loop flags not set after clearing");

    // stop state that is not being left in this cycle
    sequence s_stop_hold;
        (state_reg == ST_STOP) && !clearStop;
    endsequence

    a_timers_restart: assert property (@(posedge sys_clk) disable iff (rst)
        s_entry |=> !brakeDone && !cutoutDone)
        else $error("a delay reported done at stop entry");

    a_brake_release: assert property (@(posedge sys_clk) disable iff (rst)
        s_stop_hold ##0 brakeDone |=> (axisBrake == '0))
        else $error("axis brake still set after braking window ran out");

    // an early cut would drop the drives before they could brake under control
    a_cutout_hold: assert property (@(posedge sys_clk) disable iff (rst)
        s_stop_hold ##0 !cutoutDone |=> (driveEnable == $past(enableRequest)))
        else $error("drive enable withdrawn before the cutout delay ran out");

    a_flags_paired: assert property (@(posedge sys_clk) disable iff (rst)
        (estopActive_reg == (state_reg == ST_STOP)) && (controllerReady_reg != estopActive_reg))
        else $error("active and ready flags disagree with the stop state");

    a_run_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_RUN) |-> (followUp == '0) && (axisBrake == '0) && !programHalt)
        else $error("follow-up, brake or halt left set while running");

    a_run_no_error: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_RUN) |-> (errorCode_reg == 16'h0000))
        else $error("error number pending while running");

    a_enable_follows: assert property (@(posedge sys_clk) disable iff (rst)
        (state_reg == ST_RUN) && $past(state_reg == ST_RUN)
        |-> (driveEnable == $past(enableRequest)) && (positionLoopActive == $past(enableRequest)))
        else $error("enable or loop flags do not follow the request bits while running");

endmodule

/* tb/host_model.sv */
// host program model: drives the sequencer's register bus as the user program would
`timescale 1ns/1ns
`include "estop_map.svh"
module host_model (
    input wire logic sys_clk, // system clock
    output logic psel, // APB select
    output logic penable, // APB enable
    output logic pwrite, // APB direction
    output estop_pkg::apb_addr_t paddr, // APB byte address
    output estop_pkg::apb_data_t pwdata, // APB write data
    input wire estop_pkg::apb_data_t prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    import estop_pkg::*;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // call right after a rising edge; ok drops when the slave never answers
    task automatic xfer(input logic wr, input apb_addr_t a, input apb_data_t wd,
                        output apb_data_t rd, output logic err, output logic ok);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        ok = (pready === 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data no longer shows the old word
        pwdata <= ~wd;
        // idle edge so a following call never reassigns psel in one step
        @(posedge sys_clk);
    endtask

    // control word as the user program keeps it: button, acknowledge, reset
    task automatic write_ctrl(input axis_vec_t en, input logic req, input logic ack,
                              input logic res, output logic ok);
        apb_data_t rd;
        logic err;
        xfer(1'b1, `ESTOP_OFF_CTRL, {20'h0_0000, en, 5'h00, res, ack, req}, rd, err, ok);
    endtask
endmodule

/* tb/emergency_stop_sequencer_tb.sv */
// self-checking bench for the emergency-stop sequencer
`timescale 1ns/1ns
`include "estop_map.svh"
module emergency_stop_sequencer_tb;
    import estop_pkg::*;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, programHalt;
    apb_addr_t paddr;
    apb_data_t pwdata, prdata;
    axis_vec_t driveEnable, followUp, axisBrake, positionLoopActive;
    int failures = 0;
    int checked = 0;

    emergency_stop_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .programHalt(programHalt),
        .driveEnable(driveEnable), .followUp(followUp), .axisBrake(axisBrake),
        .positionLoopActive(positionLoopActive));
    host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input apb_data_t got, input apb_data_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_up();
        failures++;
        $display("BAD at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    task automatic bus(input logic w, input apb_addr_t a, input apb_data_t d,
                       output apb_data_t r, output logic e);
        logic ok;
        host.xfer(w, a, d, r, e, ok);
        if (ok !== 1'b1) begin
            give_up();
        end
    endtask

    task automatic rdchk(input apb_addr_t a, input apb_data_t mask, input apb_data_t exp);
        apb_data_t r;
        logic e;
        bus(1'b0, a, 32'h0000_0000, r, e);
        chk(r & mask, exp);
    endtask

    task automatic wr(input apb_addr_t a, input apb_data_t d);
        apb_data_t r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask

    // bits: {reset, acknowledge, request}
    task automatic ctl(input axis_vec_t en, input logic [2:0] bits);
        logic ok;
        host.write_ctrl(en, bits[0], bits[1], bits[2], ok);
        if (ok !== 1'b1) begin
            give_up();
        end
    endtask

    // outputs are looked at mid-cycle, where the last edge has settled
    task automatic ports(input logic h, input axis_vec_t fu, input axis_vec_t br,
                         input axis_vec_t lp, input axis_vec_t dr);
        @(negedge sys_clk);
        chk({15'h0000, programHalt, followUp, axisBrake, positionLoopActive, driveEnable},
            {15'h0000, h, fu, br, lp, dr});
        @(posedge sys_clk);
    endtask

    task automatic wait_status(input int b);
        apb_data_t r;
        logic e;
        for (int i = 0; i < 400; i++) begin
            bus(1'b0, `ESTOP_OFF_STATUS, 32'h0000_0000, r, e);
            if (r[b] === 1'b1) begin
                return;
            end
        end
        give_up();
    endtask

    task automatic stop_cycle(input axis_vec_t en);
        ctl(en, 3'b000);
        ctl(en, 3'b001);
        ports(1'b1, 4'hF, 4'hF, 4'h0, en);
        rdchk(`ESTOP_OFF_STATUS, 32'h0000_0007, 32'h0000_0005);
        rdchk(`ESTOP_OFF_ERROR, 32'h0000_FFFF, {16'h0000, `ESTOP_ERR_CODE});
        wait_status(`ESTOP_ST_REST);
        ports(1'b1, 4'hF, 4'h0, 4'h0, en);
        wait_status(`ESTOP_ST_CUT);
        ports(1'b1, 4'hF, 4'h0, 4'h0, 4'h0);
        ctl(en, 3'b000);
        ctl(en, 3'b010);
        rdchk(`ESTOP_OFF_STATUS, 32'h0000_0003, 32'h0000_0001);
        ctl(en, 3'b100);
        rdchk(`ESTOP_OFF_STATUS, 32'h0000_0003, 32'h0000_0001);
        ctl(en, 3'b111);
        rdchk(`ESTOP_OFF_STATUS, 32'h0000_0003, 32'h0000_0001);
        ctl(en, 3'b110);
        ports(1'b0, 4'h0, 4'h0, en, en);
        rdchk(`ESTOP_OFF_STATUS, 32'h0000_0007, 32'h0000_0002);
        rdchk(`ESTOP_OFF_ERROR, 32'h0000_FFFF, 32'h0000_0000);
        ctl(en, 3'b000);
        $display("test stop cycle with enables %h done", en);
    endtask

    initial begin
        apb_data_t r;
        logic e;
        rst = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdchk(`ESTOP_OFF_CTRL, 32'hFFFF_FFFF, `ESTOP_CTRL_RESET);
        rdchk(`ESTOP_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
        rdchk(`ESTOP_OFF_ERROR, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(`ESTOP_OFF_BRAKE, 32'hFFFF_FFFF, {16'h0000, `ESTOP_BRAKE_RESET});
        rdchk(`ESTOP_OFF_CUTOUT, 32'hFFFF_FFFF, {16'h0000, `ESTOP_CUTOUT_RESET});
        rdchk(`ESTOP_OFF_AXIS, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`ESTOP_OFF_STATUS, 32'hFFFF_FFFF);
        rdchk(`ESTOP_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0002);
        // unmapped word: write first, then read, both flagged
        for (int w = 1; w >= 0; w--) begin
            bus(w[0], 12'h018, 32'hFFFF_FFFF, r, e);
            chk({31'h0, e}, 32'h0000_0001);
        end
        chk(r, 32'h0000_0000);
        // short delays keep the run brief; cutout stays two ticks past braking
        wr(`ESTOP_OFF_BRAKE, 32'h0000_0001);
        wr(`ESTOP_OFF_CUTOUT, 32'h0000_0003);
        rdchk(`ESTOP_OFF_BRAKE, 32'hFFFF_FFFF, 32'h0000_0001);
        rdchk(`ESTOP_OFF_CUTOUT, 32'hFFFF_FFFF, 32'h0000_0003);
        $display("test registers done");
        stop_cycle(4'hF);
        stop_cycle(4'h5);
        report_and_stop();
    end
endmodule
